// file: hdl/vme_master.sv
// Master end: AXI4-Lite command registers driving backplane cycles
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "vme_params.svh"
module vme_master (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  vme_bus_if.master bus
);
  import vme_pkg::*;

  typedef struct packed {
    mst_sample_type sync1;
    mst_sample_type sync2;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_l;
    logic [31:0] w_l;
    logic [3:0] strb_l;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] vaddr;
    logic [31:0] am;
    logic [31:0] wdat;
    logic [15:0] rdat;
    logic busy;
    logic done;
    logic berr;
    mst_fsm_type state;
    logic [7:0] beat;
    logic [23:1] addr;
    logic [5:0] am_out;
    logic as_n;
    logic [1:0] ds_n;
    logic write_n;
    logic lword_n;
    logic iack_n;
    logic data_oe;
  } mst_state_type;

  mst_state_type s;
  mst_state_type next_s;

  // Byte lanes honoured on every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb
  begin
    mst_sample_type b;
    b = s.sync2;
    next_s = s;
    next_s.sync1.dtack_n = bus.dtack_n;
    next_s.sync1.berr_n = bus.berr_n;
    next_s.sync1.data = bus.data;
    next_s.sync2 = s.sync1;

    if (awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awready = 1'b0;
      next_s.aw_l = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wready = 1'b0;
      next_s.w_l = wdata;
      next_s.strb_l = wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      unique case (s.aw_l)
        `CTRL_OFFSET:
        begin
          next_s.ctrl = merge(s.ctrl, s.w_l, s.strb_l);
          if (s.strb_l[0] && s.w_l[0] && !s.busy)
          begin
            next_s.busy = 1'b1;
            next_s.done = 1'b0;
            next_s.berr = 1'b0;
            next_s.beat = '0;
            next_s.state = MST_ADDR;
            next_s.addr = s.vaddr[23:1];
            next_s.am_out = s.am[5:0];
            next_s.write_n = s.w_l[1];
            next_s.data_oe = !s.w_l[1];
          end
        end
        `ADDR_OFFSET: next_s.vaddr = merge(s.vaddr, s.w_l, s.strb_l);
        `AM_OFFSET: next_s.am = merge(s.am, s.w_l, s.strb_l);
        `WDATA_OFFSET: next_s.wdat = merge(s.wdat, s.w_l, s.strb_l);
        default: next_s.bresp = `RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_OKAY;
      unique case (araddr)
        `CTRL_OFFSET: next_s.rdata = s.ctrl;
        `ADDR_OFFSET: next_s.rdata = s.vaddr;
        `AM_OFFSET: next_s.rdata = s.am;
        `WDATA_OFFSET: next_s.rdata = s.wdat;
        `STATUS_OFFSET: next_s.rdata = {29'h0, s.berr, s.done, s.busy};
        `RDATA_OFFSET: next_s.rdata = {16'h0, s.rdat};
        default:
        begin
          next_s.rdata = '0;
          next_s.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    unique case (s.state)
      MST_IDLE:
      begin
      end
      MST_ADDR:
      begin
        next_s.as_n = 1'b0;
        next_s.ds_n = 2'b00;
        next_s.state = MST_STROBE;
      end
      MST_STROBE:
      begin
        if (!b.dtack_n)
        begin
          next_s.rdat = b.data;
          next_s.ds_n = 2'b11;
          next_s.state = MST_RELEASE;
        end
        else if (!b.berr_n)
        begin
          next_s.berr = 1'b1;
          next_s.ds_n = 2'b11;
          next_s.state = MST_RELEASE;
        end
      end
      MST_RELEASE:
      begin
        // No new strobe until the slave lets acknowledge go
        if (b.dtack_n && b.berr_n)
        begin
          if (s.berr || !s.ctrl[2] || s.beat == s.ctrl[15:8])
          begin
            next_s.state = MST_END;
          end
          else
          begin
            next_s.beat = s.beat + 8'h1;
            next_s.ds_n = 2'b00;
            next_s.state = MST_STROBE;
          end
        end
      end
      MST_END:
      begin
        next_s.as_n = 1'b1;
        next_s.data_oe = 1'b0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.state = MST_IDLE;
      end
    endcase

    if (!aresetn)
    begin
      next_s = '0;
      // Released open-drain lines read high
      next_s.sync1 = '1;
      next_s.sync2 = '1;
      next_s.state = MST_IDLE;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
      next_s.arready = 1'b1;
      next_s.am = {26'h0, `AM_RESET};
      next_s.am_out = `AM_RESET;
      next_s.as_n = 1'b1;
      next_s.ds_n = 2'b11;
      next_s.write_n = 1'b1;
      next_s.lword_n = 1'b1;
      next_s.iack_n = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    s <= next_s;
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign bus.addr = s.addr;
  assign bus.am = s.am_out;
  assign bus.as_n = s.as_n;
  assign bus.ds_n = s.ds_n;
  assign bus.write_n = s.write_n;
  assign bus.lword_n = s.lword_n;
  assign bus.iack_n = s.iack_n;
  assign bus.m_data_out = s.wdat[15:0];
  assign bus.m_data_oe = s.data_oe;
endmodule

// file: hdl/vme_params.svh
// Constants for the A24/D16 slave interface and its bus master end
`ifndef VME_PARAMS_SVH
`define VME_PARAMS_SVH
`define SETUP_COUNT 4'ha
`define AM_HIGH_BITS 3'h7
`define AM_NONE 2'h0
`define REG_LIMIT 15'h0080
`define SRAM_BASE 15'h4000
`define CTRL_OFFSET 8'h00
`define ADDR_OFFSET 8'h04
`define AM_OFFSET 8'h08
`define WDATA_OFFSET 8'h0c
`define STATUS_OFFSET 8'h10
`define RDATA_OFFSET 8'h14
`define AM_RESET 6'h39
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BUS_IDLE 16'hffff
`endif

// file: hdl/vme_pkg.sv
// Types shared by both ends of the backplane link
package vme_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_SETUP = 3'b001,
    DEV_STROBE_WR = 3'b010,
    DEV_ACK = 3'b011,
    DEV_ERROR = 3'b100
  } dev_fsm_type;
  typedef enum logic [2:0] {
    MST_IDLE = 3'b000,
    MST_ADDR = 3'b001,
    MST_STROBE = 3'b010,
    MST_RELEASE = 3'b011,
    MST_END = 3'b100
  } mst_fsm_type;
  typedef enum logic [1:0] {
    REGION_NONE = 2'b00,
    REGION_REG = 2'b01,
    REGION_SRAM = 2'b10
  } region_type;
  typedef struct packed {
    logic [23:1] addr;
    logic [5:0] am;
    logic as_n;
    logic [1:0] ds_n;
    logic write_n;
    logic lword_n;
    logic iack_n;
    logic [15:0] data;
    logic [7:0] base;
  } dev_sample_type;
  typedef struct packed {
    logic dtack_n;
    logic berr_n;
    logic [15:0] data;
  } mst_sample_type;
endpackage

// file: hdl/vme_bus_if.sv
// Backplane wires between the bus master end and the slave end
interface vme_bus_if;
  logic [23:1] addr;
  logic [5:0] am;
  logic as_n;
  logic [1:0] ds_n;
  logic write_n;
  logic lword_n;
  logic iack_n;
  logic [15:0] m_data_out;
  logic m_data_oe;
  logic [15:0] s_data_out;
  logic s_data_oe;
  logic dtack_oe;
  logic berr_oe;
  logic [15:0] data;
  logic dtack_n;
  logic berr_n;
  // Open-drain lines pull high when nobody drives them
  assign data = s_data_oe ? s_data_out : (m_data_oe ? m_data_out : 16'hffff);
  assign dtack_n = !dtack_oe;
  assign berr_n = !berr_oe;
  modport slave (
    input addr, am, as_n, ds_n, write_n, lword_n, iack_n, data,
    output s_data_out, s_data_oe, dtack_oe, berr_oe
  );
  modport master (
    output addr, am, as_n, ds_n, write_n, lword_n, iack_n, m_data_out, m_data_oe,
    input data, dtack_n, berr_n
  );
endinterface

// file: hdl/vme_slave.sv
// Slave end: board select, handshake sequencer and address decoder
`include "vme_params.svh"
module vme_slave (
  input wire logic aclk,
  input wire logic aresetn,
  vme_bus_if.slave bus,
  input wire logic [7:0] board_base,
  input wire logic [15:0] rd_data,
  output logic board_select_n,
  output logic any_strobe_n,
  output logic block_xfer,
  output logic write_cycle,
  output logic wr_gate_n,
  output logic rd_gate_n,
  output logic reg_cs_n,
  output logic sram_cs_n,
  output logic xcvr_oe_n,
  output logic xcvr_dir,
  output logic [15:1] local_addr,
  output logic [15:0] wr_data,
  output vme_pkg::dev_fsm_type ack_enable_state
);
  import vme_pkg::*;

  typedef struct packed {
    dev_sample_type sync1;
    dev_sample_type sync2;
    dev_fsm_type state;
    logic [3:0] count;
    logic in_block;
    logic [15:1] offset;
    logic [15:0] wr_latch;
    logic [15:0] rd_latch;
    logic write_cycle;
    logic board_select_n;
    logic any_strobe_n;
    logic block_xfer;
    logic wr_gate_n;
    logic rd_gate_n;
    logic reg_cs_n;
    logic sram_cs_n;
    logic xcvr_oe_n;
    logic xcvr_dir;
    logic data_oe;
    logic dtack_oe;
    logic berr_oe;
  } dev_state_type;

  dev_state_type s;
  dev_state_type next_s;

  // Registers low, SRAM high, the gap between answers with bus error
  function automatic region_type region_of(input logic [15:1] off);
    if (off < `REG_LIMIT)
    begin
      return REGION_REG;
    end
    else if (off >= `SRAM_BASE)
    begin
      return REGION_SRAM;
    end
    return REGION_NONE;
  endfunction

  always_comb
  begin
    dev_sample_type b;
    logic any_n;
    logic hit_n;
    logic bsel;
    logic blk;
    logic active;
    logic [15:1] cur_off;
    region_type reg_kind;
    b = s.sync2;
    any_n = 1'b1;
    hit_n = 1'b1;
    bsel = 1'b0;
    blk = 1'b0;
    active = 1'b0;
    cur_off = '0;
    reg_kind = REGION_NONE;
    next_s = s;
    // Every backplane line passes two flops before use
    next_s.sync1.addr = bus.addr;
    next_s.sync1.am = bus.am;
    next_s.sync1.as_n = bus.as_n;
    next_s.sync1.ds_n = bus.ds_n;
    next_s.sync1.write_n = bus.write_n;
    next_s.sync1.lword_n = bus.lword_n;
    next_s.sync1.iack_n = bus.iack_n;
    next_s.sync1.data = bus.data;
    next_s.sync1.base = board_base;
    next_s.sync2 = s.sync1;

    any_n = b.ds_n[1] & b.ds_n[0];
    hit_n = !(b.addr[23:16] == b.base);
    // Modifier bit 2 is ignored: privilege and program/data are alike
    bsel = b.iack_n & b.lword_n & (b.am[5:3] == `AM_HIGH_BITS)
         & (b.am[1:0] != `AM_NONE) & !b.as_n & !hit_n;
    blk = bsel & b.am[1] & b.am[0];
    // In a block transfer the address is only valid for the first beat
    cur_off = s.in_block ? s.offset : b.addr[15:1];

    if (b.as_n)
    begin
      next_s.in_block = 1'b0;
    end

    unique case (s.state)
      DEV_IDLE:
      begin
        if (bsel && !any_n)
        begin
          next_s.offset = cur_off;
          next_s.in_block = blk;
          next_s.write_cycle = !b.write_n;
          next_s.count = '0;
          if (region_of(cur_off) == REGION_NONE)
          begin
            next_s.state = DEV_ERROR;
          end
          else
          begin
            next_s.state = DEV_SETUP;
          end
        end
      end
      DEV_SETUP:
      begin
        next_s.count = s.count + 4'h1;
        if (s.count == `SETUP_COUNT - 4'h1)
        begin
          next_s.state = DEV_STROBE_WR;
        end
      end
      DEV_STROBE_WR:
      begin
        next_s.wr_latch = b.data;
        next_s.rd_latch = rd_data;
        next_s.state = DEV_ACK;
      end
      DEV_ACK:
      begin
        if (any_n)
        begin
          next_s.state = DEV_IDLE;
          if (s.in_block)
          begin
            next_s.offset = s.offset + 15'h1;
          end
        end
      end
      DEV_ERROR:
      begin
        if (any_n)
        begin
          next_s.state = DEV_IDLE;
        end
      end
    endcase

    // Outputs other than board_select_n, any_strobe_n and block_xfer follow the next state so each flop matches its state exactly
    active = (next_s.state == DEV_SETUP) || (next_s.state == DEV_STROBE_WR)
           || (next_s.state == DEV_ACK);
    reg_kind = region_of(next_s.offset);
    next_s.wr_gate_n = !(next_s.state == DEV_SETUP);
    next_s.rd_gate_n = !((next_s.state == DEV_SETUP) || (next_s.state == DEV_STROBE_WR)
                     || ((next_s.state == DEV_ACK) && !any_n));
    next_s.reg_cs_n = !(active && reg_kind == REGION_REG);
    next_s.sram_cs_n = !(active && reg_kind == REGION_SRAM);
    next_s.xcvr_oe_n = !active;
    next_s.xcvr_dir = !next_s.write_cycle;
    next_s.dtack_oe = next_s.state == DEV_ACK;
    next_s.berr_oe = next_s.state == DEV_ERROR;
    next_s.data_oe = (next_s.state == DEV_ACK) && !next_s.write_cycle;
    next_s.board_select_n = !bsel;
    next_s.any_strobe_n = any_n;
    next_s.block_xfer = blk;

    if (!aresetn)
    begin
      next_s = '0;
      // Idle line levels, so no false strobe or select follows reset
      next_s.sync1 = '1;
      next_s.sync2 = '1;
      next_s.state = DEV_IDLE;
      next_s.board_select_n = 1'b1;
      next_s.any_strobe_n = 1'b1;
      next_s.wr_gate_n = 1'b1;
      next_s.rd_gate_n = 1'b1;
      next_s.reg_cs_n = 1'b1;
      next_s.sram_cs_n = 1'b1;
      next_s.xcvr_oe_n = 1'b1;
      next_s.xcvr_dir = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    s <= next_s;
  end

  assign bus.s_data_out = s.rd_latch;
  assign bus.s_data_oe = s.data_oe;
  assign bus.dtack_oe = s.dtack_oe;
  assign bus.berr_oe = s.berr_oe;
  assign board_select_n = s.board_select_n;
  assign any_strobe_n = s.any_strobe_n;
  assign block_xfer = s.block_xfer;
  assign write_cycle = s.write_cycle;
  assign wr_gate_n = s.wr_gate_n;
  assign rd_gate_n = s.rd_gate_n;
  assign reg_cs_n = s.reg_cs_n;
  assign sram_cs_n = s.sram_cs_n;
  assign xcvr_oe_n = s.xcvr_oe_n;
  assign xcvr_dir = s.xcvr_dir;
  assign local_addr = s.offset;
  assign wr_data = s.wr_latch;
  assign ack_enable_state = s.state;
endmodule

// file: testbench/vme_link_monitor.sv
// Handshake checks on the backplane wires between the two ends
module vme_link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [23:1] addr,
  input wire logic [5:0] am,
  input wire logic as_n,
  input wire logic [1:0] ds_n,
  input wire logic lword_n,
  input wire logic iack_n,
  input wire logic dtack_oe,
  input wire logic berr_oe,
  input wire logic [7:0] board_base,
  input wire logic wr_gate_n,
  input wire logic rd_gate_n,
  input wire logic any_strobe_n,
  input wire logic block_xfer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe;
  logic resp;
  logic sel_ok;
  assign strobe = ds_n != 2'h3;
  assign resp = dtack_oe || berr_oe;
  // Master holds all select terms until answered, so they are valid at the answer
  assign sel_ok = iack_n && lword_n && am[5:3] == 3'h7 && am[1:0] != 2'h0 && !as_n &&
    addr[23:16] == board_base;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_select; $rose(resp) |-> sel_ok; endproperty
  a_select: assert property (p_select) else $error("answer unselected");
  property p_setup;
    $fell(wr_gate_n) |=> (!wr_gate_n) [*8] ##1 !wr_gate_n ##1 wr_gate_n;
  endproperty
  a_setup: assert property (p_setup) else $error("setup length");
  property p_rd_gate; !wr_gate_n |-> !rd_gate_n; endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read gate");
  property p_ack_after; $rose(dtack_oe) |-> strobe && wr_gate_n && !$past(wr_gate_n, 2);
  endproperty
  a_ack_after: assert property (p_ack_after) else $error("ack early");
  property p_hold; resp && strobe |=> $stable({dtack_oe, berr_oe}); endproperty
  a_hold: assert property (p_hold) else $error("answer dropped");
  property p_release; resp && !strobe |-> ##[1:4] !resp; endproperty
  a_release: assert property (p_release) else $error("answer stuck");
  property p_no_restart; dtack_oe && !strobe |=> !strobe; endproperty
  a_no_restart: assert property (p_no_restart) else $error("early strobe");
  property p_exclusive; !(dtack_oe && berr_oe); endproperty
  a_exclusive: assert property (p_exclusive) else $error("ack and error");
  property p_strobe_on; strobe [*4] |-> !any_strobe_n; endproperty
  a_strobe_on: assert property (p_strobe_on) else $error("strobe low");
  property p_strobe_off; (!strobe) [*4] |-> any_strobe_n; endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("strobe high");
  property p_block; $rose(dtack_oe) |-> block_xfer == (am[1:0] == 2'h3); endproperty
  a_block: assert property (p_block) else $error("block flag");
  c_block: cover property ($rose(dtack_oe) && block_xfer);
  c_single: cover property ($rose(dtack_oe) && !block_xfer);
  c_error: cover property ($rose(berr_oe));
endmodule

// file: testbench/vme_a24d16_slave_interface_tb.sv
// Bench joining the master end and the slave end over one backplane
`include "vme_params.svh"
module vme_a24d16_slave_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vme_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, prev_dt;
  logic [7:0] awaddr, araddr, board_base;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_resp;
  logic [15:0] rd_data, wr_data;
  logic board_select_n, any_strobe_n, block_xfer, write_cycle, wr_gate_n, rd_gate_n;
  logic reg_cs_n, sram_cs_n, xcvr_oe_n, xcvr_dir;
  logic [15:1] local_addr;
  dev_fsm_type ack_enable_state;
  logic [33:0] cap [$];
  logic [5:0] cap2 [$];
  logic [5:0] codes [6] = '{6'h3f, 6'h3e, 6'h3d, 6'h3b, 6'h3a, 6'h39};
  logic [5:0] refused [3] = '{6'h38, 6'h29, 6'h3d};
  int err_count, n_tests;
  vme_bus_if link();
  vme_slave u_vme_slave (.aclk, .aresetn, .bus(link), .board_base, .rd_data, .board_select_n,
    .any_strobe_n, .block_xfer, .write_cycle, .wr_gate_n, .rd_gate_n, .reg_cs_n, .sram_cs_n,
    .xcvr_oe_n, .xcvr_dir, .local_addr, .wr_data, .ack_enable_state);
  vme_master u_vme_master (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .bus(link));
  vme_link_monitor u_vme_link_monitor (.aclk, .aresetn, .addr(link.addr), .am(link.am),
    .as_n(link.as_n), .ds_n(link.ds_n), .lword_n(link.lword_n), .iack_n(link.iack_n),
    .dtack_oe(link.dtack_oe), .berr_oe(link.berr_oe), .board_base, .wr_gate_n, .rd_gate_n,
    .any_strobe_n, .block_xfer);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // One record per acknowledged beat
  always @(posedge aclk)
  begin
    prev_dt <= link.dtack_oe;
    if (prev_dt === 1'b0 && link.dtack_oe === 1'b1)
    begin
      cap.push_back({local_addr, write_cycle, reg_cs_n, sram_cs_n, wr_data});
      cap2.push_back({xcvr_oe_n, xcvr_dir, block_xfer, ack_enable_state});
    end
  end
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (50000) @(posedge aclk);
    err_count++;
    final_report();
  end
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    // Ready stays high between calls, so it is never lowered and raised in one step
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_resp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    last_resp = rresp;
  endtask
  // Offset is a byte offset; the go bit alone starts a cycle
  task automatic xfer(input logic [5:0] m, input logic [15:0] off, input logic [15:0] ctl,
    output logic [31:0] st);
    int n;
    axi_wr(`AM_OFFSET, {26'h0, m});
    axi_wr(`ADDR_OFFSET, {8'h0, board_base, off});
    axi_wr(`CTRL_OFFSET, {16'h0, ctl});
    check(34'(last_resp), 34'(`RESP_OKAY));
    n = 0;
    do
    begin
      axi_rd(`STATUS_OFFSET, st);
      n++;
    end
    while (st[1] !== 1'b1 && n < 200);
  endtask
  function automatic logic [17:0] expect_beat(logic [15:0] off, int j, logic wr);
    logic [15:1] w;
    w = off[15:1] + 15'(j);
    return {w, wr, !(w < `REG_LIMIT), !(w >= `SRAM_BASE)};
  endfunction
  initial
  begin
    logic [31:0] st, rv;
    logic [15:0] off, d, rdv;
    logic [7:0] beats;
    logic blk, wr, bad;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'had6b));
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, rd_data} = 64'h0;
    wstrb = 4'hf;
    board_base = 8'($urandom);
    do_reset();
    check(34'({board_select_n, wr_gate_n, rd_gate_n, sram_cs_n, link.dtack_n}), 34'h1f);
    for (int i = 0; i < 12; i++)
    begin
      wr = i[0];
      blk = codes[i / 2][1:0] == 2'h3;
      beats = blk ? 8'($urandom_range(3)) : 8'h0;
      off = $urandom_range(1) ? 16'(2 * $urandom_range(32)) : 16'(16'h8000 + 2 * $urandom_range(4000));
      d = 16'($urandom);
      rdv = 16'($urandom);
      rd_data <= rdv;
      if (wr)
        axi_wr(`WDATA_OFFSET, {16'h0, d});
      cap.delete();
      cap2.delete();
      xfer(codes[i / 2], off, {beats, 5'h0, blk, !wr, 1'b1}, st);
      check(34'(st[2:0]), 34'h2);
      check(34'(cap.size()), 34'(beats) + 34'h1);
      for (int j = 0; j < cap.size(); j++)
      begin
        check(34'(cap[j][33:16]), 34'(expect_beat(off, j, wr)));
        check(34'(cap2[j]), 34'({1'b0, !wr, blk, DEV_ACK}));
        if (wr)
          check(34'(cap[j][15:0]), 34'(d));
      end
      if (!wr)
      begin
        axi_rd(`RDATA_OFFSET, rv);
        check(34'(rv), 34'(rdv));
      end
    end
    cap.delete();
    xfer(6'h39, 16'h2000, 16'h1, st);
    check(34'(st[2:0]), 34'h6);
    check(34'(cap.size()), 34'h0);
    // Refused cycles never end on their own, so each is cleared by a reset
    for (int i = 0; i < 3; i++)
    begin
      axi_wr(`AM_OFFSET, 32'(refused[i]));
      axi_wr(`ADDR_OFFSET, {8'h0, board_base ^ 8'(i == 2), 16'h0010});
      axi_wr(`CTRL_OFFSET, 32'h1);
      bad = 1'b0;
      repeat (40)
      begin
        @(posedge aclk);
        bad = bad | (board_select_n !== 1'b1) | (link.dtack_n !== 1'b1);
      end
      check(34'(bad), 34'h0);
      axi_rd(`STATUS_OFFSET, st);
      check(34'(st[0]), 34'h1);
      do_reset();
    end
    axi_rd(8'h1c, rv);
    check({last_resp, rv}, {`RESP_SLVERR, 32'h0});
    final_report();
  end
endmodule
